/* File: ctp_pkg.sv */
// Purpose: Shared constants for the capture unit timer pair block.
// Assumes: 32-bit AHB-Lite register bus, 16-bit byte addresses, 100 MHz module clock.
// Notes: Timer index 0/1 is unit A first/second, 2/3 is unit B first/second.
package ctp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CTP_NUM_TIMERS = 4;
  localparam int CTP_NUM_PINS = 2;
  localparam int CTP_COUNT_WIDTH = 16;
  localparam int CTP_PRESC_WIDTH = 10;
  localparam int CTP_ADDR_WIDTH = 16;
  localparam int CTP_DATA_WIDTH = 32;
  localparam int CTP_CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] CTP_OFS_PAIR_A_CONTROL = 16'hff50;
  localparam logic [15:0] CTP_OFS_PAIR_B_CONTROL = 16'hff20;
  localparam logic [15:0] CTP_OFS_COUNT_BASE = 16'hff00;
  localparam logic [15:0] CTP_OFS_RELOAD_BASE = 16'hff10;
  localparam logic [15:0] CTP_OFS_CONFIG = 16'hff30;
  localparam logic [15:0] CTP_OFS_IRQ_STATUS = 16'hff34;
  localparam logic [15:0] CTP_OFS_IRQ_MASK = 16'hff38;
  localparam logic [15:0] CTP_OFS_STRIDE = 16'h0004;

  // ----------------------------------------------------------------
  // Field positions inside one control byte, and the byte layout
  // ----------------------------------------------------------------
  localparam int CTP_RUN_POS = 6;
  localparam int CTP_MODE_POS = 3;
  localparam int CTP_SEL_LSB = 0;
  localparam int CTP_SEL_WIDTH = 3;
  localparam int CTP_HIGH_BYTE_LSB = 8;
  localparam int CTP_STAGGER_POS = 0;
  localparam logic [15:0] CTP_CONTROL_WMASK = 16'h4f4f;
  localparam logic [3:0] CTP_STAGGER_ADD = 4'h3;

  // ----------------------------------------------------------------
  // Counter mode input select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CTP_SEL_AUX = 3'h0;
  localparam logic [2:0] CTP_SEL_RISE = 3'h1;
  localparam logic [2:0] CTP_SEL_FALL = 3'h2;
  localparam logic [2:0] CTP_SEL_BOTH = 3'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CTP_RST_CONTROL = 16'h0000;
  localparam logic [15:0] CTP_RST_COUNT = 16'h0000;
  localparam logic [15:0] CTP_RST_RELOAD = 16'h0000;
  localparam logic [3:0] CTP_RST_IRQ = 4'h0;

  // Bus data phase states, Gray coded along idle-write and idle-read.
  typedef enum logic [1:0] {
    CTP_BUS_IDLE = 2'b00,
    CTP_BUS_WRITE = 2'b01,
    CTP_BUS_READ = 2'b10
  } ctp_bus_state_type;

endpackage

/* File: ctp_timer_core.sv */
// Purpose: One 16-bit up-counting timer with its own free-running prescaler.
// Assumes: Event input is a one-cycle pulse synchronous to the clock.
// Notes: The overflow output is combinational and marks the edge of the reload.
`timescale 1ns/1ns
module ctp_timer_core #(
  parameter int COUNT_WIDTH = ctp_pkg::CTP_COUNT_WIDTH,
  parameter int PRESC_WIDTH = ctp_pkg::CTP_PRESC_WIDTH
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic run_in,
  input wire logic counter_mode_in,
  input wire logic [3:0] exponent_in,
  input wire logic event_in,
  input wire logic count_we_in,
  input wire logic reload_we_in,
  input wire logic [COUNT_WIDTH-1:0] wdata_in,
  output logic [COUNT_WIDTH-1:0] count_out,
  output logic [COUNT_WIDTH-1:0] reload_out,
  output logic overflow_out
);
  import ctp_pkg::*;

  logic [PRESC_WIDTH-1:0] presc;
  logic [PRESC_WIDTH-1:0] presc_mask;
  logic tick;
  logic trigger;

  // The widest exponent is seven plus the stagger offset, so a narrower prescaler would lose rates.
  if (PRESC_WIDTH < 10 || COUNT_WIDTH < 2) begin : g_param_check
    $error("Timer core parameters out of range.");
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // The prescaler never stops, so the increment phase is fixed and a
  // start lands within one resolution interval.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  // A tick fires when the low exponent bits are all ones, giving a rate of clock over two to the exponent.
  always_comb begin
    presc_mask = PRESC_WIDTH'((1 << exponent_in) - 1);
    tick = ((presc & presc_mask) == presc_mask);
  end

  // Run flag gates every source; mode picks prescaled clock or events.
  assign trigger = run_in && (counter_mode_in ? event_in : tick);
  // Overflow is a trigger seen at the all-ones value, dropped under a count write.
  assign overflow_out = trigger && !count_we_in && (count_out == {COUNT_WIDTH{1'b1}});

  // ----------------------------------------------------------------
  // Count and reload
  // ----------------------------------------------------------------
  // Software write wins over increment or reload in the same cycle.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_out <= COUNT_WIDTH'(CTP_RST_COUNT);
    end else if (count_we_in) begin
      count_out <= wdata_in;
    end else if (trigger) begin
      if (count_out == {COUNT_WIDTH{1'b1}}) begin
        count_out <= reload_out;
      end else begin
        count_out <= count_out + 1'b1;
      end
    end
  end

  // Reload register, zero after reset.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reload_out <= COUNT_WIDTH'(CTP_RST_RELOAD);
    end else if (reload_we_in) begin
      reload_out <= wdata_in;
    end
  end

endmodule

/* File: ctp_timer_pair.sv */
// Purpose: Four up-counting time bases of two capture units, behind an AHB-Lite slave.
// Assumes: Bus and the auxiliary overflow pulse are synchronous to clk_sys_in; pins may be asynchronous.
// Notes: Reads take one wait state so that read data comes from a flip-flop.
`timescale 1ns/1ns

// Contract
// - A timer counts only while its run flag (bits 14 and 6) is set.
// - Mode bit (11 and 3) chooses prescaled clock (0) or events (1).
// - Input select field sits at bits 10:8 and 2:0 per timer.
// - Counter select: 000 aux overflow, 001 rise, 010 fall, 011 both; 1XX forbidden.
// - Second timers count only aux overflows in counter mode, else they stop.
// - Timer rate is clock over two to select, plus three when staggered.
// - Each timer owns a prescaler driven by its own select field and the shared stagger bit.
// - A trigger at all ones loads the reload value instead of wrapping.
// - Overflow period is two-to-sixteen minus reload, times the prescale factor.
// - First increment within one interval after start, then exactly one interval apart.
// - Timers only count up; software reads and writes every count.
// - A count write in an increment or reload cycle wins and suppresses it.
// - Each overflow raises its own interrupt flag together with the reload.
// - Reload registers read zero after reset.
module ctp_timer_pair (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic hsel_in,
  input wire logic [ctp_pkg::CTP_ADDR_WIDTH-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [ctp_pkg::CTP_DATA_WIDTH-1:0] hwdata_in,
  input wire logic hready_in,
  input wire logic aux_timer_overflow_in,
  input wire logic external_count_pin_a_in,
  input wire logic external_count_pin_b_in,
  output logic [ctp_pkg::CTP_DATA_WIDTH-1:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic irq_out,
  output logic [ctp_pkg::CTP_NUM_TIMERS-1:0] overflow_out
);
  import ctp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ctp_bus_state_type bus_state;
  logic [CTP_ADDR_WIDTH-1:0] bus_addr;
  logic addr_phase;
  logic wr_en;
  logic [15:0] timer_pair_a_control;
  logic [15:0] timer_pair_b_control;
  logic stagger_mode;
  logic [CTP_NUM_TIMERS-1:0] irq_status;
  logic [CTP_NUM_TIMERS-1:0] irq_mask;
  logic [CTP_NUM_TIMERS-1:0] ovf;
  logic [CTP_NUM_TIMERS-1:0] count_we;
  logic [CTP_NUM_TIMERS-1:0] reload_we;
  logic [CTP_COUNT_WIDTH-1:0] count_val [CTP_NUM_TIMERS];
  logic [CTP_COUNT_WIDTH-1:0] reload_val [CTP_NUM_TIMERS];
  logic [CTP_NUM_PINS-1:0] pin_raw;
  logic [CTP_NUM_PINS-1:0] pin_meta;
  logic [CTP_NUM_PINS-1:0] pin_sync;
  logic [CTP_NUM_PINS-1:0] pin_prev;
  logic [CTP_NUM_PINS-1:0] pin_rise;
  logic [CTP_NUM_PINS-1:0] pin_fall;
  logic [CTP_DATA_WIDTH-1:0] next_rdata;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The largest exponent is seven plus the stagger offset, so the
  // prescaler must hold at least ten bits.
  if (CTP_PRESC_WIDTH < 10) begin : g_presc_check
    $error("Prescaler too narrow for the largest division factor.");
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Only NONSEQ and SEQ start a transfer; IDLE and BUSY are ignored.
  assign addr_phase = hsel_in && htrans_in[1] && hready_in;
  assign wr_en = (bus_state == CTP_BUS_WRITE);

  // Data phase tracking; the address is kept for the decode in the data phase.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_state <= CTP_BUS_IDLE;
      bus_addr <= '0;
    end else if (addr_phase) begin
      bus_state <= hwrite_in ? CTP_BUS_WRITE : CTP_BUS_READ;
      bus_addr <= haddr_in;
    end else begin
      case (bus_state)
        CTP_BUS_WRITE: bus_state <= CTP_BUS_IDLE;
        CTP_BUS_READ: bus_state <= CTP_BUS_IDLE;
        default: bus_state <= CTP_BUS_IDLE;
      endcase
    end
  end

  // A read stalls one cycle so that hrdata comes straight from a flop;
  // writes complete with no wait state.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hreadyout_out <= 1'b1;
    end else if (addr_phase && !hwrite_in) begin
      hreadyout_out <= 1'b0;
    end else if (bus_state == CTP_BUS_READ) begin
      hreadyout_out <= 1'b1;
    end
  end

  // Every transfer, mapped or not, answers OKAY.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hresp_out <= 1'b0;
    end else begin
      hresp_out <= 1'b0;
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    next_rdata = '0;
    case (bus_addr)
      CTP_OFS_PAIR_A_CONTROL: next_rdata[15:0] = timer_pair_a_control;
      CTP_OFS_PAIR_B_CONTROL: next_rdata[15:0] = timer_pair_b_control;
      CTP_OFS_CONFIG: next_rdata[CTP_STAGGER_POS] = stagger_mode;
      CTP_OFS_IRQ_STATUS: next_rdata[CTP_NUM_TIMERS-1:0] = irq_status;
      CTP_OFS_IRQ_MASK: next_rdata[CTP_NUM_TIMERS-1:0] = irq_mask;
      default: next_rdata = '0;
    endcase
    for (int k = 0; k < CTP_NUM_TIMERS; k++) begin
      if (bus_addr == 16'(CTP_OFS_COUNT_BASE + k * CTP_OFS_STRIDE)) begin
        next_rdata[15:0] = count_val[k];
      end
      if (bus_addr == 16'(CTP_OFS_RELOAD_BASE + k * CTP_OFS_STRIDE)) begin
        next_rdata[15:0] = reload_val[k];
      end
    end
  end

  // Read data is captured during the wait state and then held.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hrdata_out <= '0;
    end else if (bus_state == CTP_BUS_READ) begin
      hrdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------
  // Unused control bits are kept at zero by the write mask.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer_pair_a_control <= CTP_RST_CONTROL;
      timer_pair_b_control <= CTP_RST_CONTROL;
    end else if (wr_en) begin
      if (bus_addr == CTP_OFS_PAIR_A_CONTROL) begin
        timer_pair_a_control <= hwdata_in[15:0] & CTP_CONTROL_WMASK;
      end
      if (bus_addr == CTP_OFS_PAIR_B_CONTROL) begin
        timer_pair_b_control <= hwdata_in[15:0] & CTP_CONTROL_WMASK;
      end
    end
  end

  // Staggered operation is a unit-wide choice shared by all four timers.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stagger_mode <= 1'b0;
    end else if (wr_en && bus_addr == CTP_OFS_CONFIG) begin
      stagger_mode <= hwdata_in[CTP_STAGGER_POS];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Overflow sets its sticky bit on the reload edge; a new overflow in
  // the cycle of a write-one-to-clear keeps the bit set.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_status <= CTP_RST_IRQ;
    end else if (wr_en && bus_addr == CTP_OFS_IRQ_STATUS) begin
      irq_status <= (irq_status & ~hwdata_in[CTP_NUM_TIMERS-1:0]) | ovf;
    end else begin
      irq_status <= irq_status | ovf;
    end
  end

  // Mask register, one enable per status bit.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_mask <= CTP_RST_IRQ;
    end else if (wr_en && bus_addr == CTP_OFS_IRQ_MASK) begin
      irq_mask <= hwdata_in[CTP_NUM_TIMERS-1:0];
    end
  end

  // The interrupt level lags the status by one cycle to stay a flop output.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
      overflow_out <= '0;
    end else begin
      irq_out <= |(irq_status & irq_mask);
      overflow_out <= ovf;
    end
  end

  // ----------------------------------------------------------------
  // External count pins
  // ----------------------------------------------------------------
  assign pin_raw = {external_count_pin_b_in, external_count_pin_a_in};

  // Two-flop synchroniser, then a third flop for edge detection; the
  // first stage feeds only the second.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // One pulse per detected edge, so one increment per edge.
  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < CTP_NUM_TIMERS; i++) begin : g_timer
    localparam int UNIT = i / 2;
    localparam bit SECOND = (i % 2) == 1;
    localparam int BYTE_LSB = SECOND ? CTP_HIGH_BYTE_LSB : 0;
    logic [15:0] ctrl;
    logic run;
    logic counter_mode;
    logic [CTP_SEL_WIDTH-1:0] sel;
    logic [3:0] exponent;
    logic event_pulse;

    // Upper byte steers the second timer, lower byte the first.
    assign ctrl = (UNIT == 0) ? timer_pair_a_control : timer_pair_b_control;
    assign run = ctrl[BYTE_LSB + CTP_RUN_POS];
    assign counter_mode = ctrl[BYTE_LSB + CTP_MODE_POS];
    assign sel = ctrl[BYTE_LSB + CTP_SEL_LSB +: CTP_SEL_WIDTH];

    // Each timer's exponent depends on its own field and the shared stagger bit.
    assign exponent = {1'b0, sel} + (stagger_mode ? CTP_STAGGER_ADD : 4'h0);

    // Counter mode source decode; reserved codes and pin codes on a
    // second timer give no events, which stops it.
    always_comb begin
      event_pulse = 1'b0;
      case (sel)
        CTP_SEL_AUX: event_pulse = aux_timer_overflow_in;
        CTP_SEL_RISE: event_pulse = !SECOND && pin_rise[UNIT];
        CTP_SEL_FALL: event_pulse = !SECOND && pin_fall[UNIT];
        CTP_SEL_BOTH: event_pulse = !SECOND && (pin_rise[UNIT] || pin_fall[UNIT]);
        default: event_pulse = 1'b0;
      endcase
    end

    // Write strobes for this timer's count and reload words.
    assign count_we[i] = wr_en && (bus_addr == 16'(CTP_OFS_COUNT_BASE + i * CTP_OFS_STRIDE));
    assign reload_we[i] = wr_en && (bus_addr == 16'(CTP_OFS_RELOAD_BASE + i * CTP_OFS_STRIDE));

    ctp_timer_core #(
      .COUNT_WIDTH(CTP_COUNT_WIDTH),
      .PRESC_WIDTH(CTP_PRESC_WIDTH)
    ) u_core (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .run_in(run),
      .counter_mode_in(counter_mode),
      .exponent_in(exponent),
      .event_in(event_pulse),
      .count_we_in(count_we[i]),
      .reload_we_in(reload_we[i]),
      .wdata_in(hwdata_in[CTP_COUNT_WIDTH-1:0]),
      .count_out(count_val[i]),
      .reload_out(reload_val[i]),
      .overflow_out(ovf[i])
    );
  end

endmodule

/* File: ctp_timer_pair_props.sv */
// Purpose: Port-level properties of the timer pair block.
// Assumes: hready_in is fed back from hreadyout_out.
// Notes: An irq rise is checked against overflow_out in the rise cycle or an irq register write two cycles back; a fall against that write only.
`timescale 1ns/1ns
module ctp_timer_pair_props (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic hsel_in,
  input wire logic [ctp_pkg::CTP_ADDR_WIDTH-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [ctp_pkg::CTP_DATA_WIDTH-1:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic irq_out,
  input wire logic [ctp_pkg::CTP_NUM_TIMERS-1:0] overflow_out
);
  import ctp_pkg::*;
  logic taken;
  logic irq_wr;
  // ------------------------------------------------------------
  // Helper logic and properties
  // ------------------------------------------------------------
  // Flags the data phase of a write to status or mask, the only bus cause of an irq change.
  assign taken = hsel_in & htrans_in[1] & hready_in;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_wr <= 1'b0;
    end else begin
      irq_wr <= taken & hwrite_in & ((haddr_in == CTP_OFS_IRQ_STATUS) | (haddr_in == CTP_OFS_IRQ_MASK));
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence s_rd_taken;
    taken && !hwrite_in;
  endsequence
  sequence s_one_wait;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  a_read_one_wait: assert property (s_rd_taken |=> s_one_wait)
    else $error("read wait state not exactly one cycle");
  a_write_no_wait: assert property (taken && hwrite_in |=> hreadyout_out)
    else $error("write inserted a wait state");
  a_wait_has_cause: assert property (!hreadyout_out |-> $past(taken && !hwrite_in))
    else $error("wait state without a read");
  a_ready_idle: assert property (!(taken && !hwrite_in) |=> hreadyout_out)
    else $error("ready dropped with no read taken");
  a_resp_okay: assert property (hresp_out == 1'b0)
    else $error("response not okay");
  a_rdata_hold: assert property ($changed(hrdata_out) |-> $rose(hreadyout_out))
    else $error("read data changed outside a read completion");
  a_irq_rise_cause: assert property ($rose(irq_out) |-> (|overflow_out) || $past(irq_wr, 2))
    else $error("irq rose with no overflow or mask write");
  a_irq_fall_cause: assert property ($fell(irq_out) |-> $past(irq_wr, 2))
    else $error("irq fell with no status or mask write");
endmodule
bind ctp_timer_pair ctp_timer_pair_props i_props (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .irq_out(irq_out), .overflow_out(overflow_out)
);

/* File: tb_top.sv */
// Purpose: Self-checking bench for the timer pair block over AHB-Lite.
// Assumes: One master, single word transfers, hready fed back from hreadyout.
// Notes: Rates are measured between overflow pulses, so no count is shortened.
`timescale 1ns/1ns
module tb_top;
  import ctp_pkg::*;
  logic clk_sys_in;
  logic reset_n_in;
  logic hsel;
  logic [15:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic aux;
  logic [1:0] pin;
  logic [31:0] hrdata;
  logic hready;
  logic irq;
  logic [3:0] ovf;
  logic [31:0] rd;
  logic [15:0] ca;
  logic [15:0] cb;
  int err_count;
  int comparisons;
  int per;
  int st;
  int s;
  int u;
  ctp_timer_pair i_dut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .aux_timer_overflow_in(aux),
    .external_count_pin_a_in(pin[0]), .external_count_pin_b_in(pin[1]), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(), .irq_out(irq), .overflow_out(ovf)
  );
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Every bounded wait ends here when it runs dry, so a hang still gives a verdict.
  task automatic hang(input string what);
    err_count++;
    $display("[FAIL] %0t timeout waiting for %s", $time, what);
    report_and_stop();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
      if (n > 16) begin
        hang("hready");
      end
    end while (hready !== 1'b1);
  endtask
  // Address phase held until hready, then the data phase until hready again; read data taken there.
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic wait_ovf(input int i, output int c);
    c = 0;
    do begin
      @(posedge clk_sys_in);
      c++;
      if (c > 9000) begin
        hang("overflow");
      end
    end while (ovf[i] !== 1'b1);
  endtask
  // Four transitions, two rising and two falling, spaced well past the synchroniser delay.
  task automatic edges(input int k);
    repeat (4) begin
      repeat (6) @(posedge clk_sys_in);
      pin[k] <= ~pin[k];
    end
    repeat (6) @(posedge clk_sys_in);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys_in);
      aux <= 1'b1;
      @(posedge clk_sys_in);
      aux <= 1'b0;
    end
    repeat (2) @(posedge clk_sys_in);
  endtask
  // ------------------------------------------------------------
  // Clock and test sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    reset_n_in = 1'b0;
    hsel = 1'b0;
    haddr = 16'h0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    aux = 1'b0;
    pin = 2'b00;
    err_count = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    // Reset values, the control bit layout and an unmapped word.
    for (u = 0; u < 4; u++) begin
      rdc(CTP_OFS_RELOAD_BASE + 16'(4 * u), 32'h0000_0000);
      rdc(CTP_OFS_COUNT_BASE + 16'(4 * u), 32'h0000_0000);
    end
    rdc(CTP_OFS_PAIR_A_CONTROL, 32'h0000_0000);
    bus(1'b1, CTP_OFS_PAIR_B_CONTROL, 32'hffff_ffff);
    rdc(CTP_OFS_PAIR_B_CONTROL, 32'h0000_4f4f);
    bus(1'b1, CTP_OFS_PAIR_B_CONTROL, 32'h0000_0000);
    bus(1'b1, 16'hff40, 32'hffff_ffff);
    rdc(16'hff40, 32'h0000_0000);
    $display("test reset_values done");
    // Both timers of pair A run at once on different selects; overflow spacing shows rate and reload.
    for (st = 0; st < 2; st++) begin
      for (s = 0; s < 3; s++) begin
        bus(1'b1, CTP_OFS_CONFIG, 32'(st));
        bus(1'b1, CTP_OFS_RELOAD_BASE, 32'h0000_fff0);
        bus(1'b1, CTP_OFS_RELOAD_BASE + CTP_OFS_STRIDE, 32'h0000_ffc0);
        bus(1'b1, CTP_OFS_COUNT_BASE, 32'h0000_fff0);
        bus(1'b1, CTP_OFS_COUNT_BASE + CTP_OFS_STRIDE, 32'h0000_ffc0);
        bus(1'b1, CTP_OFS_PAIR_A_CONTROL, 32'h0000_4040 | 32'(s) | (32'(s + 1) << 8));
        wait_ovf(0, per);
        wait_ovf(0, per);
        chk(32'(per), 32'(16 << (s + 3 * st)));
        wait_ovf(1, per);
        wait_ovf(1, per);
        chk(32'(per), 32'(64 << (s + 1 + 3 * st)));
      end
    end
    bus(1'b1, CTP_OFS_PAIR_A_CONTROL, 32'h0000_0000);
    bus(1'b1, CTP_OFS_COUNT_BASE, 32'h0000_1234);
    repeat (40) @(posedge clk_sys_in);
    rdc(CTP_OFS_COUNT_BASE, 32'h0000_1234);
    $display("test timer_rates done");
    // Sticky flags stay hidden until unmasked, then clear by writing ones.
    rdc(CTP_OFS_IRQ_STATUS, 32'h0000_0003);
    chk(32'(irq), 32'h0000_0000);
    bus(1'b1, CTP_OFS_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge clk_sys_in);
    chk(32'(irq), 32'h0000_0001);
    bus(1'b1, CTP_OFS_IRQ_STATUS, 32'h0000_0002);
    repeat (2) @(posedge clk_sys_in);
    chk(32'(irq), 32'h0000_0000);
    rdc(CTP_OFS_IRQ_STATUS, 32'h0000_0001);
    rdc(CTP_OFS_IRQ_MASK, 32'h0000_0002);
    bus(1'b1, CTP_OFS_IRQ_MASK, 32'h0000_0000);
    $display("test interrupts done");
    // Pin edges per select code on both first timers, then auxiliary events on both timers of a pair.
    for (u = 0; u < 2; u++) begin
      ca = (u == 1) ? CTP_OFS_PAIR_B_CONTROL : CTP_OFS_PAIR_A_CONTROL;
      cb = CTP_OFS_COUNT_BASE + 16'(8 * u);
      for (s = 1; s < 4; s++) begin
        bus(1'b1, ca, 32'h0000_0000);
        bus(1'b1, cb, 32'h0000_0000);
        bus(1'b1, ca, 32'h0000_0048 | 32'(s));
        edges(u);
        rdc(cb, (s == 3) ? 32'h0000_0004 : 32'h0000_0002);
      end
      bus(1'b1, ca, 32'h0000_0000);
      bus(1'b1, cb, 32'h0000_0000);
      bus(1'b1, cb + CTP_OFS_STRIDE, 32'h0000_0000);
      bus(1'b1, ca, 32'h0000_4848);
      pulses(5);
      rdc(cb, 32'h0000_0005);
      rdc(cb + CTP_OFS_STRIDE, 32'h0000_0005);
      bus(1'b1, ca, 32'h0000_4948);
      pulses(3);
      edges(u);
      rdc(cb + CTP_OFS_STRIDE, 32'h0000_0005);
      rdc(cb, 32'h0000_0008);
      bus(1'b1, ca, 32'h0000_0000);
    end
    $display("test counter_mode done");
    report_and_stop();
  end
endmodule
